// File: shared/wdr_pkg.sv
/*
  Package for the watchdog / discharge-timer reset control block.
  Holds register offsets, field positions, reset values and time counts.
  Assumes a 40 MHz clock and an APB slave with 32-bit data.
*/
package wdr_pkg;

  // ------------------------------------------------------------
  // Clock and times
  // ------------------------------------------------------------
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned WD_TIME_S = 2;
  localparam longint unsigned WD_CYCLES = longint'(WD_TIME_S) * CLK_HZ;
  // Discharge timer counts in half-minute ticks of 30 s
  localparam int unsigned TICK_TIME_S = 30;
  localparam longint unsigned TICK_CYCLES =
    longint'(TICK_TIME_S) * CLK_HZ;

  // ------------------------------------------------------------
  // Register byte addresses
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_CFGA_LO = 8'h00;
  localparam logic [7:0] ADDR_CFGA_HI = 8'h04;
  localparam logic [7:0] ADDR_CFGB = 8'h08;
  localparam logic [7:0] ADDR_S_PIN_CONTROL_GROUP = 8'h0C;
  localparam logic [7:0] ADDR_PWM = 8'h10;
  localparam logic [7:0] ADDR_PSB = 8'h14;
  localparam logic [7:0] ADDR_COMM_LO = 8'h18;
  localparam logic [7:0] ADDR_COMM_HI = 8'h1C;
  localparam logic [7:0] ADDR_CMD = 8'h20;
  localparam logic [7:0] ADDR_STATUS = 8'h24;

  // ------------------------------------------------------------
  // Fields
  // ------------------------------------------------------------
  localparam int unsigned DISCHARGE_TIMEOUT_CODE_LSB = 12;
  localparam int unsigned MON_EN_BIT = 3;
  localparam int unsigned MUTE_BIT = 7;
  localparam int unsigned CMD_VALID_BIT = 0;
  localparam int unsigned CMD_WRA_BIT = 1;
  localparam int unsigned CMD_THSD_BIT = 2;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [31:0] RST_PWM = 32'hFFFFFFFF;
  localparam logic [31:0] RST_COMM = 32'hFFFFFFFF;

  typedef enum logic [1:0] {
    ST_STANDBY = 2'b00,
    ST_EXT_BAL = 2'b01,
    ST_SLEEP = 2'b10
  } wdr_state_t;

  // Clear actions from the decision logic
  typedef struct packed {
    logic a0;
    logic a13;
    logic a45;
    logic b0_gpio;
    logic b0_hi;
    logic b1_low;
    logic b1_mute;
    logic s_pin_control_group;
    logic pwm;
    logic comm;
    logic dis_off;
  } wdr_clr_t;

endpackage

// File: shared/wdr_evt_if.sv
/*
  Interface carrying timer events between the timers and the core.
  Assumes all parties run on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none
interface wdr_evt_if;
  logic wd_restart;
  logic wd_fire;
  logic wd_expired;
  logic dt_load;
  logic [3:0] dt_code;
  logic dt_stop;
  logic dt_fire;
  logic dt_running;
  logic [3:0] dt_left;
  modport core (output wd_restart, dt_load, dt_code, dt_stop,
    input wd_fire, wd_expired, dt_fire, dt_running, dt_left);
  modport wd (input wd_restart, output wd_fire, wd_expired);
  modport dt (input dt_load, dt_code, dt_stop,
    output dt_fire, dt_running, dt_left);
endinterface
`default_nettype wire

// File: rtl/wdr_watchdog.sv
/*
  Command watchdog: 2 s without a valid command fires once.
  Assumes restart pulses come from logic on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none
module wdr_watchdog
  import wdr_pkg::*;
#(
  parameter longint unsigned WD_LIMIT = WD_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  wdr_evt_if.wd ev
);

  typedef struct packed {
    logic [31:0] cnt;
    logic expired;
    logic fire;
  } wdr_wd_t;

  wdr_wd_t s_q, s_d;

  // ------------------------------------------------------------
  // Counter
  // ------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.fire = 1'b0;
    if (ev.wd_restart) begin
      s_d.cnt = 32'h00000000;
      s_d.expired = 1'b0;
    end else if (!s_q.expired) begin
      if (s_q.cnt >= 32'(WD_LIMIT - 1)) begin
        s_d.expired = 1'b1;
        s_d.fire = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt + 32'h00000001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign ev.wd_fire = s_q.fire;
  assign ev.wd_expired = s_q.expired;

endmodule
`default_nettype wire

// File: rtl/wdr_dis_timer.sv
/*
  Discharge timer: loads a code, counts 30 s ticks, reports time left.
  Assumes load and stop pulses come from the same clock.
*/
`timescale 1ns/100ps
`default_nettype none
module wdr_dis_timer
  import wdr_pkg::*;
#(
  parameter longint unsigned TICK_LIMIT = TICK_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  wdr_evt_if.dt ev
);

  typedef struct packed {
    logic [31:0] pre;
    logic [7:0] ticks;
    logic run;
    logic fire;
    logic [3:0] left;
  } wdr_dt_t;

  wdr_dt_t s_q, s_d;

  // Duration in 30 s ticks per code
  function automatic logic [7:0] dur(input logic [3:0] c);
    case (c)
      4'h1: dur = 8'h01;
      4'h2: dur = 8'h02;
      4'h3: dur = 8'h04;
      4'h4: dur = 8'h06;
      4'h5: dur = 8'h08;
      4'h6: dur = 8'h0A;
      4'h7: dur = 8'h14;
      4'h8: dur = 8'h1E;
      4'h9: dur = 8'h28;
      4'hA: dur = 8'h3C;
      4'hB: dur = 8'h50;
      4'hC: dur = 8'h78;
      4'hD: dur = 8'h96;
      4'hE: dur = 8'hB4;
      4'hF: dur = 8'hF0;
      default: dur = 8'h00;
    endcase
  endfunction

  // Smallest code whose bound covers the remaining ticks
  function automatic logic [3:0] code_of(input logic [7:0] t);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 15; i >= 1; i--) begin
      if (t != 8'h00 && dur(4'(i)) >= t) begin
        r = 4'(i);
      end
    end
    code_of = r;
  endfunction

  // ------------------------------------------------------------
  // Countdown
  // ------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.fire = 1'b0;
    if (ev.dt_stop) begin
      s_d.run = 1'b0;
      s_d.ticks = 8'h00;
      s_d.pre = 32'h00000000;
    end else if (ev.dt_load) begin
      s_d.ticks = dur(ev.dt_code);
      s_d.run = (ev.dt_code != 4'h0);
      s_d.pre = 32'h00000000;
    end else if (s_q.run) begin
      // Counts on through any command except a reload or a thermal stop
      if (s_q.pre >= 32'(TICK_LIMIT - 1)) begin
        s_d.pre = 32'h00000000;
        s_d.ticks = s_q.ticks - 8'h01;
        if (s_q.ticks == 8'h01) begin
          s_d.run = 1'b0;
          s_d.fire = 1'b1;
        end
      end else begin
        s_d.pre = s_q.pre + 32'h00000001;
      end
    end
    // Partial tick rounds up, so code_of stays conservative
    s_d.left = s_d.run ? code_of(s_d.ticks) : 4'h0;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign ev.dt_fire = s_q.fire;
  assign ev.dt_running = s_q.run;
  assign ev.dt_left = s_q.left;

endmodule
`default_nettype wire

// File: rtl/wdr_ctrl.sv
/*
  Watchdog and discharge-timer reset control with APB register file.
  Assumes an APB master on REF_CLK; the enable pin is asynchronous.
*/
// Decided for this implementation: the register addresses and the APB register port.
`timescale 1ns/100ps
`default_nettype none
module wdr_ctrl
  import wdr_pkg::*;
#(
  parameter longint unsigned WD_LIMIT = WD_CYCLES,
  parameter longint unsigned TICK_LIMIT = TICK_CYCLES
) (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic DISCHARGE_TIMER_ENABLE_PIN,
  output logic WATCHDOG_OUTPUT_PIN_O,
  output logic WATCHDOG_OUTPUT_PIN_OE,
  output logic DISCHARGE_ON,
  output logic [1:0] OP_STATE
);

  typedef struct packed {
    logic [5:0][7:0] cfga;
    logic [1:0][7:0] cfgb;
    logic [31:0] s_pin_control_group;
    logic [31:0] pwm;
    logic [31:0] psb;
    logic [47:0] comm;
    wdr_state_t st;
    logic dis_on;
    logic [1:0] pin_sync;
    logic [31:0] rdata;
  } wdr_top_t;

  wdr_top_t s_q, s_d;
  wdr_evt_if ev();
  wdr_clr_t clr;
  logic wr_en, rd_en, pin_en, cmd_wr, valid_cmd, wra_cmd, thsd;
  logic [3:0] code_wr;

  wdr_watchdog #(.WD_LIMIT(WD_LIMIT)) u_wd (
    .clk(REF_CLK),
    .rst(RST),
    .ev(ev)
  );

  wdr_dis_timer #(.TICK_LIMIT(TICK_LIMIT)) u_dt (
    .clk(REF_CLK),
    .rst(RST),
    .ev(ev)
  );

  // ------------------------------------------------------------
  // Bus strobes and command decode
  // ------------------------------------------------------------
  assign wr_en = PSEL && PENABLE && PWRITE;
  assign rd_en = PSEL && !PENABLE && !PWRITE;
  assign pin_en = s_q.pin_sync[1];
  assign cmd_wr = wr_en && (PADDR == ADDR_CMD);
  assign valid_cmd = cmd_wr && PWDATA[CMD_VALID_BIT];
  assign wra_cmd = valid_cmd && PWDATA[CMD_WRA_BIT];
  assign thsd = cmd_wr && PWDATA[CMD_THSD_BIT];
  assign code_wr = s_q.cfga[3][7:4];

  assign ev.wd_restart = valid_cmd;
  // Reload only when a config A write command completes
  assign ev.dt_load = wra_cmd && pin_en;
  assign ev.dt_code = code_wr;
  assign ev.dt_stop = !pin_en || thsd;

  // ------------------------------------------------------------
  // Clear decision
  // ------------------------------------------------------------
  always_comb begin
    clr = '0;
    if (ev.wd_fire && !ev.dt_running) begin
      // Full clear covers both timer-off settings
      clr = '1;
    end else if (ev.wd_fire) begin
      clr.a0 = 1'b1;
      clr.a13 = !s_q.cfgb[1][MON_EN_BIT];
      clr.b0_gpio = 1'b1;
      clr.b1_mute = 1'b1;
      clr.comm = 1'b1;
    end
    if (ev.dt_fire && ev.wd_expired) begin
      clr = '1;
    end else if (ev.dt_fire) begin
      clr.a13 = clr.a13 | s_q.cfgb[1][MON_EN_BIT];
      clr.a45 = 1'b1;
      clr.b0_hi = 1'b1;
      clr.b1_low = 1'b1;
      clr.s_pin_control_group = 1'b1;
      clr.pwm = 1'b1;
      clr.dis_off = 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Register update
  // ------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.pin_sync = {s_q.pin_sync[0], DISCHARGE_TIMER_ENABLE_PIN};
    if (clr.a0) s_d.cfga[0] = RST_BYTE;
    if (clr.a13) s_d.cfga[3:1] = '0;
    if (clr.a45) s_d.cfga[5:4] = '0;
    if (clr.b0_gpio) s_d.cfgb[0][3:0] = 4'h0;
    if (clr.b0_hi) s_d.cfgb[0][7:4] = 4'h0;
    if (clr.b1_low) s_d.cfgb[1][6:0] = 7'h00;
    if (clr.b1_mute) s_d.cfgb[1][MUTE_BIT] = 1'b0;
    if (clr.s_pin_control_group) s_d.s_pin_control_group = 32'h00000000;
    if (clr.pwm) begin
      s_d.pwm = RST_PWM;
      s_d.psb = RST_PWM;
    end
    if (clr.comm) s_d.comm = {RST_COMM[15:0], RST_COMM};
    if (clr.dis_off) s_d.dis_on = 1'b0;
    if (thsd) begin
      s_d.cfga = '0;
      s_d.cfgb[0] = 8'h00;
      s_d.cfgb[1][6:0] = 7'h00;
      s_d.comm = {RST_COMM[15:0], RST_COMM};
      s_d.dis_on = 1'b0;
    end
    // Bus writes land after clears so new config A data wins
    if (wr_en) begin
      if (PADDR == ADDR_CFGA_LO) begin
        s_d.cfga[3:0] = PWDATA;
      end else if (PADDR == ADDR_CFGA_HI) begin
        s_d.cfga[5:4] = PWDATA[15:0];
      end else if (PADDR == ADDR_CFGB) begin
        s_d.cfgb = PWDATA[15:0];
      end else if (PADDR == ADDR_S_PIN_CONTROL_GROUP) begin
        s_d.s_pin_control_group = PWDATA;
      end else if (PADDR == ADDR_PWM) begin
        s_d.pwm = PWDATA;
      end else if (PADDR == ADDR_PSB) begin
        s_d.psb = PWDATA;
      end else if (PADDR == ADDR_COMM_LO) begin
        s_d.comm[31:0] = PWDATA;
      end else if (PADDR == ADDR_COMM_HI) begin
        s_d.comm[47:32] = PWDATA[15:0];
      end
    end
    // Thermal event in the same write keeps discharge off
    if (wra_cmd && !thsd) s_d.dis_on = 1'b1;
    // State transitions
    if (valid_cmd) begin
      s_d.st = ST_STANDBY;
    end
    if (ev.wd_fire) begin
      s_d.st = ev.dt_running ? ST_EXT_BAL : ST_SLEEP;
      if (!ev.dt_running) s_d.dis_on = 1'b0;
    end
    if (ev.dt_fire && ev.wd_expired) begin
      s_d.st = ST_SLEEP;
      s_d.dis_on = 1'b0;
    end
    // Read data captured in setup phase
    s_d.rdata = 32'h00000000;
    if (rd_en) begin
      if (PADDR == ADDR_CFGA_LO) begin
        s_d.rdata = {s_q.cfga[3][7:4], 4'h0, s_q.cfga[2], s_q.cfga[1],
          s_q.cfga[0]};
        s_d.rdata[DISCHARGE_TIMEOUT_CODE_LSB + 16 +: 4] = ev.dt_left;
        s_d.rdata[31:28] = ev.dt_left;
        s_d.rdata[27:24] = s_q.cfga[3][3:0];
      end else if (PADDR == ADDR_CFGA_HI) begin
        s_d.rdata = {16'h0000, s_q.cfga[5], s_q.cfga[4]};
      end else if (PADDR == ADDR_CFGB) begin
        s_d.rdata = {16'h0000, s_q.cfgb[1], s_q.cfgb[0]};
      end else if (PADDR == ADDR_S_PIN_CONTROL_GROUP) begin
        s_d.rdata = s_q.s_pin_control_group;
      end else if (PADDR == ADDR_PWM) begin
        s_d.rdata = s_q.pwm;
      end else if (PADDR == ADDR_PSB) begin
        s_d.rdata = s_q.psb;
      end else if (PADDR == ADDR_COMM_LO) begin
        s_d.rdata = s_q.comm[31:0];
      end else if (PADDR == ADDR_COMM_HI) begin
        s_d.rdata = {16'h0000, s_q.comm[47:32]};
      end else if (PADDR == ADDR_STATUS) begin
        s_d.rdata = {26'h0000000, ev.wd_expired, ev.dt_running,
          s_q.dis_on, pin_en, s_q.st};
      end
    end else if (PSEL && PENABLE) begin
      s_d.rdata = s_q.rdata;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      s_q <= '0;
      s_q.pwm <= RST_PWM;
      s_q.psb <= RST_PWM;
      s_q.comm <= {RST_COMM[15:0], RST_COMM};
      s_q.st <= ST_STANDBY;
    end else begin
      s_q <= s_d;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  // Pin released (enable low) while alive; driven low when expired
  assign WATCHDOG_OUTPUT_PIN_O = 1'b0;
  assign WATCHDOG_OUTPUT_PIN_OE = ev.wd_expired;
  assign DISCHARGE_ON = s_q.dis_on;
  assign OP_STATE = s_q.st;
  assign PRDATA = s_q.rdata;
  assign PREADY = 1'b1;
  assign PSLVERR = 1'b0;

endmodule
`default_nettype wire

// File: dv/wdr_ctrl_checker.sv
/*
  Assertions on the reset control block's top ports.
  Assumes the bind below attaches it to every wdr_ctrl.
*/
`timescale 1ns/100ps
`default_nettype none
module wdr_ctrl_checker
  import wdr_pkg::*;
#(
  parameter longint unsigned WD_LIMIT = WD_CYCLES
) (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic DISCHARGE_TIMER_ENABLE_PIN,
  input wire logic WATCHDOG_OUTPUT_PIN_O,
  input wire logic WATCHDOG_OUTPUT_PIN_OE,
  input wire logic DISCHARGE_ON,
  input wire logic [1:0] OP_STATE
);
  // ------------------------
  // Idle count since command
  // ------------------------
  logic [31:0] idle_q;
  logic cmd_wr;
  assign cmd_wr = PSEL && PENABLE && PWRITE && PADDR == ADDR_CMD;
  always_ff @(posedge REF_CLK) begin
    if (RST || (cmd_wr && PWDATA[CMD_VALID_BIT])) begin
      idle_q <= 32'h0;
    end else if (idle_q != 32'hFFFFFFFF) begin
      idle_q <= idle_q + 32'h1;
    end
  end
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);
  sequence thsd_s;
    cmd_wr && PWDATA[CMD_THSD_BIT];
  endsequence
  sequence off_s;
    ##[1:3] !DISCHARGE_ON;
  endsequence
  // ----------
  // Properties
  // ----------
  reset_idle_a: assert property ($past(RST) |->
    OP_STATE == ST_STANDBY && !DISCHARGE_ON && PRDATA == 32'h0)
    else $error("state not default after reset");
  pin_low_a: assert property (WATCHDOG_OUTPUT_PIN_O == 1'h0)
    else $error("watchdog pin driven high");
  wd_early_a: assert property ($rose(WATCHDOG_OUTPUT_PIN_OE) |->
    idle_q >= WD_LIMIT - 1) else $error("watchdog fired early");
  wd_late_a: assert property (idle_q > WD_LIMIT + 4 |->
    WATCHDOG_OUTPUT_PIN_OE) else $error("watchdog did not expire");
  sleep_off_a: assert property (OP_STATE == ST_SLEEP |->
    !DISCHARGE_ON && WATCHDOG_OUTPUT_PIN_OE)
    else $error("sleep with discharge on or pin held");
  ext_bal_a: assert property ($rose(OP_STATE == ST_EXT_BAL) |->
    DISCHARGE_ON && $past(OP_STATE) == ST_STANDBY)
    else $error("bad entry to extended balancing");
  ext_pin_a: assert property (OP_STATE == ST_EXT_BAL |->
    WATCHDOG_OUTPUT_PIN_OE) else $error("pin held in balancing");
  thermal_off_a: assert property (thsd_s |-> off_s)
    else $error("discharge kept after thermal event");
endmodule
bind wdr_ctrl wdr_ctrl_checker #(.WD_LIMIT(WD_LIMIT)) chk (.REF_CLK, .RST,
  .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR,
  .DISCHARGE_TIMER_ENABLE_PIN, .WATCHDOG_OUTPUT_PIN_O,
  .WATCHDOG_OUTPUT_PIN_OE, .DISCHARGE_ON, .OP_STATE);
`default_nettype wire

// File: dv/wdr_host_model.sv
/*
  Host model: APB master issuing register and command traffic.
  Assumes one clock shared with the block.
*/
`timescale 1ns/100ps
`default_nettype none
module wdr_host_model (
  input wire logic clk,
  input wire logic pready,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  output logic hang
);
  initial begin
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    hang = 1'h0;
  end
  // ------------
  // One transfer
  // ------------
  task automatic xfer(input logic wr, input logic [7:0] a,
    input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'h1 && n < 64);
    if (pready !== 1'h1) hang <= 1'h1;
    // Released lines flip, so stale values never pass
    psel <= 1'h0;
    penable <= 1'h0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule
`default_nettype wire

// File: dv/testbench.sv
/*
  Bench for wdr_ctrl: timer scenarios, read scoreboard, verdict.
  Assumes shortened watchdog and tick counts.
*/
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin errors++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module testbench
  import wdr_pkg::*;
;
  logic ref_clk, rst, pin, hang, psel, penable, pwrite, pready, pslverr;
  logic wdo, wdoe, dis_on;
  logic [7:0] paddr;
  logic [1:0] op_state;
  logic [31:0] pwdata, prdata, va, vh, vb, vs, e, m;
  logic [31:0] exp_q[$], msk_q[$];
  int errors, cmp_count, n;
  initial begin
    ref_clk = 1'h0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  wdr_host_model host (.clk(ref_clk), .pready(pready), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .hang(hang));
  wdr_ctrl #(.WD_LIMIT(50), .TICK_LIMIT(20)) uut (.REF_CLK(ref_clk),
    .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .DISCHARGE_TIMER_ENABLE_PIN(pin),
    .WATCHDOG_OUTPUT_PIN_O(wdo), .WATCHDOG_OUTPUT_PIN_OE(wdoe),
    .DISCHARGE_ON(dis_on), .OP_STATE(op_state));
  // ----------------
  // Read scoreboard
  // ----------------
  always @(posedge ref_clk) begin
    if (psel && penable && pready && !pwrite && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      m = msk_q.pop_front();
      `CHK(prdata & m, e & m)
    end
  end
  always @(posedge hang) begin
    errors++;
    close_out();
  end
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x,
    input logic [31:0] k);
    exp_q.push_back(x);
    msk_q.push_back(k);
    host.xfer(1'h0, a, 32'h0);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'h1, a, d);
  endtask
  task automatic cmd(input logic [31:0] d);
    wr(ADDR_CMD, d);
    repeat (2) @(posedge ref_clk);
  endtask
  task automatic do_rst(input logic p);
    rst <= 1'h1;
    pin <= p;
    repeat (8) @(posedge ref_clk);
    rst <= 1'h0;
  endtask
  // Monitor enable set so bytes 1-3 survive the watchdog while the discharge timer runs
  task automatic fill(input logic [3:0] code);
    va = $urandom();
    va[31:28] = code;
    vh = $urandom() & 32'hFFFF;
    vb = ($urandom() & 32'hFFFF) | 32'h0800;
    vs = $urandom() & 32'hFFFF;
    wr(ADDR_CFGA_LO, va);
    wr(ADDR_CFGA_HI, vh);
    wr(ADDR_CFGB, vb);
    wr(ADDR_S_PIN_CONTROL_GROUP, vs);
    wr(ADDR_PWM, $urandom());
    wr(ADDR_COMM_LO, $urandom());
  endtask
  task automatic wait_st(input logic [1:0] s);
    n = 0;
    while (op_state !== s && n < 400) begin
      @(posedge ref_clk);
      n++;
    end
    if (n == 400) begin
      errors++;
      close_out();
    end
    repeat (2) @(posedge ref_clk);
  endtask
  // ---------
  // Scenarios
  // ---------
  initial begin
    rst = 1'h1;
    pin = 1'h0;
    errors = 0;
    cmp_count = 0;
    void'($urandom(32'hDF6A));
    do_rst(1'h0);
    rd(ADDR_CFGA_LO, 32'h0, 32'hFFFFFFFF);
    rd(ADDR_PWM, RST_PWM, 32'hFFFFFFFF);
    rd(ADDR_COMM_LO, RST_COMM, 32'hFFFFFFFF);
    wr(8'h28, 32'hFFFFFFFF);
    rd(8'h28, 32'h0, 32'hFFFFFFFF);
    `CHK({dis_on, op_state}, {1'h0, ST_STANDBY})
    $display("defaults test done");
    for (int p = 0; p < 2; p++) begin
      do_rst(p[0]);
      fill(p[0] ? 4'h0 : 4'h3);
      cmd(32'h3);
      rd(ADDR_STATUS, 32'h0, 32'h10);
      wait_st(ST_SLEEP);
      `CHK({dis_on, wdoe, wdo}, 3'h2)
      rd(ADDR_CFGA_LO, 32'h0, 32'hFFFFFFFF);
      rd(ADDR_CFGA_HI, 32'h0, 32'hFFFF);
      rd(ADDR_CFGB, 32'h0, 32'hFFFF);
      rd(ADDR_S_PIN_CONTROL_GROUP, 32'h0, 32'hFFFF);
      rd(ADDR_PWM, RST_PWM, 32'hFFFFFFFF);
    end
    $display("watchdog sleep test done");
    do_rst(1'h1);
    fill(4'h3);
    cmd(32'h3);
    `CHK(dis_on, 1'h1)
    rd(ADDR_CFGA_LO, va, 32'hFFFFFFFF);
    rd(ADDR_STATUS, 32'h10, 32'h10);
    wait_st(ST_EXT_BAL);
    `CHK({dis_on, wdoe}, 2'h3)
    rd(ADDR_CFGA_LO, va & 32'h0FFFFF00, 32'h0FFFFFFF);
    rd(ADDR_CFGB, vb & 32'h7FF0, 32'hFFFF);
    rd(ADDR_COMM_LO, RST_COMM, 32'hFFFFFFFF);
    wait_st(ST_SLEEP);
    `CHK(dis_on, 1'h0)
    rd(ADDR_CFGA_LO, 32'h0, 32'hFFFFFFFF);
    rd(ADDR_S_PIN_CONTROL_GROUP, 32'h0, 32'hFFFF);
    $display("extended balancing test done");
    do_rst(1'h1);
    fill(4'h1);
    cmd(32'h3);
    for (n = 0; n < 40 && dis_on === 1'h1; n++) begin
      cmd(32'h1);
    end
    `CHK({dis_on, wdoe, op_state}, {2'h0, ST_STANDBY})
    if (n == 40) begin
      errors++;
      close_out();
    end
    rd(ADDR_CFGA_LO, va & 32'hFF, 32'hFFFFFFFF);
    rd(ADDR_CFGA_HI, 32'h0, 32'hFFFF);
    rd(ADDR_CFGB, vb & 32'h800F, 32'hFFFF);
    rd(ADDR_S_PIN_CONTROL_GROUP, 32'h0, 32'hFFFF);
    rd(ADDR_PWM, RST_PWM, 32'hFFFFFFFF);
    wr(ADDR_CFGA_LO, va);
    cmd(32'h3);
    rd(ADDR_CFGA_LO, va, 32'h0FFFFFFF);
    `CHK(dis_on, 1'h1)
    $display("discharge expiry test done");
    do_rst(1'h1);
    fill(4'h3);
    cmd(32'h3);
    cmd(32'h5);
    `CHK(dis_on, 1'h0)
    rd(ADDR_CFGA_LO, 32'h0, 32'h0FFFFFFF);
    rd(ADDR_CFGB, vb & 32'h8000, 32'hFFFF);
    rd(ADDR_S_PIN_CONTROL_GROUP, vs, 32'hFFFF);
    rd(ADDR_COMM_LO, RST_COMM, 32'hFFFFFFFF);
    $display("thermal test done");
    repeat (2) @(posedge ref_clk);
    close_out();
  end
endmodule
`default_nettype wire
